// [rtl/lbt9_fifo.sv]
// parameterised valid/ready fifo
// assumes same clock and synchronous reset as its user
`timescale 1ns/1ps
module lbt9_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rd_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [rtl/lbt9_pkg.sv]
// package for the nine-lane latching bus transceiver
// assumes a single core clock; no software registers
package lbt9_pkg;
	localparam int LBT9_LANES = 9;
	localparam int LBT9_FIFO_DEPTH = 8;
	localparam logic [8:0] LBT9_RST_DATA = 9'h000;
	localparam logic [8:0] LBT9_BUS_IDLE = 9'h1ff;

	typedef logic [LBT9_LANES-1:0] lbt9_word_t;

	// control inputs that travel together
	typedef struct packed {
		logic chip_disable;
		logic transmit;
		logic register_bypass;
		logic receive_latch_enable;
		logic capture_clk;
	} lbt9_ctrl_t;

	typedef enum logic [1:0] {
		LBT9_OFF = 2'b00,
		LBT9_TX = 2'b01,
		LBT9_RX = 2'b10
	} lbt9_mode_t;
endpackage

// [rtl/lbt9_xcvr.sv]
// nine-lane inverting latching transceiver, logic side to open-drain bus
// assumes all control and pin inputs are asynchronous and get synchronised
`timescale 1ns/1ps
module lbt9_xcvr
	import lbt9_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire lbt9_pkg::lbt9_ctrl_t ctrl_i,
	input wire lbt9_pkg::lbt9_word_t logic_side_port_i,
	output lbt9_pkg::lbt9_word_t logic_side_port_o,
	output lbt9_pkg::lbt9_word_t logic_side_port_oe_o,
	input wire lbt9_pkg::lbt9_word_t bus_side_port_i,
	output lbt9_pkg::lbt9_word_t bus_side_port_o,
	output lbt9_pkg::lbt9_word_t bus_side_port_oe_o,
	output logic tx_ready_o
);
	import lbt9_pkg::*;

	lbt9_ctrl_t ctrl_m_r, ctrl_s_r;
	lbt9_word_t a_m_r, a_s_r, b_m_r, b_s_r;
	logic clk_d_r;
	logic [2:0] sync_vld_r;
	lbt9_word_t tx_reg_r, rx_latch_r, tx_word;
	lbt9_word_t fifo_out;
	logic fifo_valid;
	logic fifo_in_ready;
	logic cap_edge;
	logic tx_load;
	lbt9_mode_t mode;

	// two-stage synchronisers on every pin
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctrl_m_r <= '{chip_disable: 1'b1, default: 1'b0};
			ctrl_s_r <= '{chip_disable: 1'b1, default: 1'b0};
			a_m_r <= LBT9_RST_DATA;
			a_s_r <= LBT9_RST_DATA;
			b_m_r <= LBT9_BUS_IDLE;
			b_s_r <= LBT9_BUS_IDLE;
			clk_d_r <= 1'b0;
			sync_vld_r <= '0;
		end else begin
			sync_vld_r <= {sync_vld_r[1:0], 1'b1};
			ctrl_m_r <= ctrl_i;
			ctrl_s_r <= ctrl_m_r;
			a_m_r <= logic_side_port_i;
			a_s_r <= a_m_r;
			b_m_r <= bus_side_port_i;
			b_s_r <= b_m_r;
			clk_d_r <= ctrl_s_r.capture_clk;
		end
	end

	always_comb begin
		if (ctrl_s_r.chip_disable) begin
			mode = LBT9_OFF;
		end else if (ctrl_s_r.transmit) begin
			mode = LBT9_TX;
		end else begin
			mode = LBT9_RX;
		end
	end

	// rising edge detect
	// masked until clk_d_r holds a real sample, else a pin held high
	// through reset would look like a fresh edge
	assign cap_edge = ctrl_s_r.capture_clk && !clk_d_r && sync_vld_r[2];
	assign tx_load = ctrl_s_r.register_bypass || cap_edge;

	// captured words pass through the fifo, which out_ready_i tied high drains one word per cycle
	lbt9_fifo #(
		.WIDTH(LBT9_LANES),
		.DEPTH(LBT9_FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.in_data_i(a_s_r),
		.in_valid_i(tx_load),
		.in_ready_o(fifo_in_ready),
		.out_data_o(fifo_out),
		.out_valid_o(fifo_valid),
		.out_ready_i(1'b1)
	);

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tx_reg_r <= LBT9_RST_DATA;
		end else if (fifo_valid) begin
			tx_reg_r <= fifo_out;
		end
	end

	assign tx_word = tx_reg_r;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rx_latch_r <= LBT9_RST_DATA;
		end else if (ctrl_s_r.receive_latch_enable) begin
			rx_latch_r <= ~b_s_r;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			logic_side_port_o <= LBT9_RST_DATA;
			logic_side_port_oe_o <= '0;
			bus_side_port_o <= '0;
			bus_side_port_oe_o <= '0;
			tx_ready_o <= 1'b0;
		end else begin
			// bus output value is always low
			bus_side_port_o <= '0;
			tx_ready_o <= fifo_in_ready;
			logic_side_port_o <= rx_latch_r;
			case (mode)
				LBT9_TX: begin
					// logic one pulls the lane low
					bus_side_port_oe_o <= tx_word;
					logic_side_port_oe_o <= '0;
				end
				LBT9_RX: begin
					bus_side_port_oe_o <= '0;
					logic_side_port_oe_o <= '1;
				end
				default: begin
					bus_side_port_oe_o <= '0;
					logic_side_port_oe_o <= '0;
				end
			endcase
		end
	end

	property p_disable_release;
		@(posedge core_clk_i) disable iff (srst_i)
		ctrl_s_r.chip_disable |=> (bus_side_port_oe_o == '0) && (logic_side_port_oe_o == '0);
	endproperty
	a_disable_release: assert property (p_disable_release)
		else $error("disabled chip still drives");

	property p_open_drain;
		@(posedge core_clk_i) disable iff (srst_i)
		bus_side_port_o == '0;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("bus driven high");

	property p_tx_drive;
		@(posedge core_clk_i) disable iff (srst_i)
		(mode == LBT9_TX) |=> bus_side_port_oe_o == $past(tx_reg_r);
	endproperty
	a_tx_drive: assert property (p_tx_drive)
		else $error("bus lanes not following transmit register");

	property p_rx_mode;
		@(posedge core_clk_i) disable iff (srst_i)
		(mode == LBT9_RX) |=> (logic_side_port_oe_o == '1) && (bus_side_port_oe_o == '0);
	endproperty
	a_rx_mode: assert property (p_rx_mode)
		else $error("receive mode drive wrong");

	property p_rx_invert;
		@(posedge core_clk_i) disable iff (srst_i)
		ctrl_s_r.receive_latch_enable |=> rx_latch_r == ~$past(b_s_r);
	endproperty
	a_rx_invert: assert property (p_rx_invert)
		else $error("receive data not inverted");

	property p_rx_hold;
		@(posedge core_clk_i) disable iff (srst_i)
		!ctrl_s_r.receive_latch_enable |=> $stable(rx_latch_r);
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("receive latch changed while closed");

	property p_bypass_flow;
		@(posedge core_clk_i) disable iff (srst_i)
		ctrl_s_r.register_bypass |-> ##2 tx_reg_r == $past(a_s_r, 2);
	endproperty
	a_bypass_flow: assert property (p_bypass_flow)
		else $error("bypass data did not pass through");

	property p_hold_no_edge;
		@(posedge core_clk_i) disable iff (srst_i)
		(!tx_load && !fifo_valid) |=> $stable(tx_reg_r);
	endproperty
	a_hold_no_edge: assert property (p_hold_no_edge)
		else $error("transmit register moved without edge");

	property p_edge_capture;
		@(posedge core_clk_i) disable iff (srst_i)
		(cap_edge && !ctrl_s_r.register_bypass) |-> ##2 tx_reg_r == $past(a_s_r, 2);
	endproperty
	a_edge_capture: assert property (p_edge_capture)
		else $error("edge capture lost");

	c_tx: cover property (@(posedge core_clk_i) mode == LBT9_TX && bus_side_port_oe_o != '0);
	c_rx: cover property (@(posedge core_clk_i) mode == LBT9_RX && logic_side_port_oe_o == '1);
	c_off: cover property (@(posedge core_clk_i) mode == LBT9_OFF);
	c_edge: cover property (@(posedge core_clk_i) cap_edge && !ctrl_s_r.register_bypass);
endmodule

// [verif/latching_bus_transceiver_9bit_test.sv]
// bench for the nine-lane transceiver: table rows, then hand cases
// assumes lbt9_pkg and the bus model are compiled first
`timescale 1ns/1ps
module latching_bus_transceiver_9bit_test;
	import lbt9_pkg::*;
	typedef struct {
		lbt9_ctrl_t c;
		lbt9_word_t a;
		lbt9_word_t p;
		lbt9_word_t lo;
		lbt9_word_t loe;
		lbt9_word_t boe;
		lbt9_word_t w;
	} lbt9_row_t;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	lbt9_ctrl_t ctrl = 5'h10;
	lbt9_word_t a_in = 9'h000;
	lbt9_word_t pull = 9'h000;
	lbt9_word_t lo, loe, bo, boe, lvl;
	logic rdy;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	lbt9_row_t rows [4];
	initial forever #50 core_clk_i = ~core_clk_i;
	lbt9_xcvr i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .ctrl_i(ctrl),
		.logic_side_port_i(a_in), .logic_side_port_o(lo), .logic_side_port_oe_o(loe),
		.bus_side_port_i(lvl), .bus_side_port_o(bo), .bus_side_port_oe_o(boe),
		.tx_ready_o(rdy));
	lbt9_bus_model i_bus (.dut_oe_i(boe), .other_pull_i(pull), .level_o(lvl));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ceiling well above the roughly 120 cycles the tests need
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic check(string n, lbt9_word_t seen, lbt9_word_t exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// sync chain plus fifo needs about five edges; eight leaves margin
	task automatic apply(lbt9_ctrl_t c, lbt9_word_t a, lbt9_word_t p);
		@(negedge core_clk_i);
		ctrl = c;
		a_in = a;
		pull = p;
		repeat (8) @(negedge core_clk_i);
	endtask
	initial begin
		// ctrl bits: disable, transmit, bypass, latch enable, capture clock
		rows[0] = '{5'h18, 9'h1a5, 9'h000, 9'h000, 9'h000, 9'h000, 9'h1ff};
		rows[1] = '{5'h0c, 9'h1a5, 9'h002, 9'h000, 9'h000, 9'h1a5, 9'h058};
		rows[2] = '{5'h02, 9'h1a5, 9'h0f0, 9'h0f0, 9'h1ff, 9'h000, 9'h10f};
		rows[3] = '{5'h02, 9'h000, 9'h10b, 9'h10b, 9'h1ff, 9'h000, 9'h0f4};
		repeat (4) @(negedge core_clk_i);
		check("reset boe", boe, 9'h000);
		check("reset loe", loe, 9'h000);
		check("reset rdy", {8'h00, rdy}, 9'h000);
		$display("reset done");
		srst_i = 1'b0;
		for (int i = 0; i < 4; i++) begin
			apply(rows[i].c, rows[i].a, rows[i].p);
			check("lo", lo, rows[i].lo);
			check("loe", loe, rows[i].loe);
			check("boe", boe, rows[i].boe);
			check("wire", lvl, rows[i].w);
			check("bus out", bo, 9'h000);
			$display("row %0d done", i);
		end
		apply(5'h00, 9'h000, 9'h000);
		check("latch hold", lo, 9'h10b);
		$display("latch hold done");
		apply(5'h0c, 9'h0aa, 9'h000);
		apply(5'h08, 9'h0aa, 9'h000);
		apply(5'h08, 9'h155, 9'h000);
		check("no edge", boe, 9'h0aa);
		apply(5'h09, 9'h155, 9'h000);
		apply(5'h08, 9'h000, 9'h000);
		check("captured", boe, 9'h155);
		check("captured wire", lvl, 9'h0aa);
		$display("capture done");
		// mid-run reset with the capture clock pin held high throughout
		@(negedge core_clk_i);
		srst_i = 1'b1;
		ctrl = 5'h09;
		a_in = 9'h1ff;
		repeat (4) @(negedge core_clk_i);
		check("mid reset boe", boe, 9'h000);
		check("mid reset lo", lo, 9'h000);
		check("mid reset rdy", {8'h00, rdy}, 9'h000);
		srst_i = 1'b0;
		repeat (8) @(negedge core_clk_i);
		check("no false edge", boe, 9'h000);
		check("ready back", {8'h00, rdy}, 9'h001);
		$display("mid reset done");
		apply(5'h18, 9'h000, 9'h000);
		check("off boe", boe, 9'h000);
		check("off loe", loe, 9'h000);
		$display("disable done");
		end_of_test();
	end
endmodule

// [verif/lbt9_bus_model.sv]
// backplane lanes: pull-ups plus one other wired-or transceiver
// assumes an enable high pulls its lane low
`timescale 1ns/1ps
module lbt9_bus_model
	import lbt9_pkg::*;
(
	input wire lbt9_pkg::lbt9_word_t dut_oe_i,
	input wire lbt9_pkg::lbt9_word_t other_pull_i,
	output lbt9_pkg::lbt9_word_t level_o
);
	// wired-or lanes
	// released lanes go to the pull-up level, never hold a stale value
	assign level_o = ~(dut_oe_i | other_pull_i);
endmodule
